// >>> core/clk_select_cfg.svh
/*
 Constants for the system clock source select block: register offsets,
 field positions, reset values and timing counts. Assumes a 100 MHz clock.
*/
`ifndef CLK_SELECT_CFG_SVH
`define CLK_SELECT_CFG_SVH

`define ADDR_CLKSRC        8'ha9
`define ADDR_EXTOSC        8'hb1
`define ADDR_IRQ_STATUS    8'hc0
`define ADDR_IRQ_MASK      8'hc1
`define ADDR_STATUS        8'hc2

`define CLKSRC_RESET       8'h00
`define EXTOSC_RESET       8'h00
`define MASK_RESET         8'h00

`define EXT_VALID_BIT      7
`define EXT_MODE_HI        6
`define EXT_MODE_LO        4
`define EXT_RANGE_HI       2
`define EXT_RANGE_LO       0

`define SRC_INT_HF         2'b00
`define SRC_EXT            2'b01
`define SRC_INT_LF         2'b10
`define SRC_RESERVED       2'b11

`define IRQ_VALID_RISE     0
`define IRQ_VALID_FALL     1
`define IRQ_BAD_SELECT     2

`define CLK_HZ             100000000
`define XTAL_SETTLE_US     1000
`define XTAL_SETTLE_CYC    ((`XTAL_SETTLE_US * (`CLK_HZ / 1000000)))

`endif

// >>> core/clk_select_pkg.sv
/*
 Types for the system clock source select block.
 Assumes the constants header is available for offsets and counts.
*/
package clk_select_pkg;
   typedef enum logic [1:0] {
      OSC_OFF   = 2'b00,
      OSC_CMOS  = 2'b01,
      OSC_RC    = 2'b10,
      OSC_XTAL  = 2'b11
   } osc_kind_t;

   typedef struct packed {
      logic [2:0] mode;
      logic [2:0] range;
   } ext_osc_cfg_t;

   typedef struct packed {
      logic       enable;
      logic       crystal;
      logic       osc_good;
   } qual_in_t;
endpackage

// >>> core/osc_qualifier.sv
/*
 Qualifies the external oscillator: counts a settle window after enable
 in crystal mode and raises valid once the window has passed and the
 oscillator reports good. Assumes inputs synchronous to clk_i.
*/
`timescale 1ns/1ns
`default_nettype none
module osc_qualifier #(
   parameter int SETTLE_CYC = 100000
) (
   input  wire logic                      clk_i,
   input  wire logic                      rst_i,
   input  wire clk_select_pkg::qual_in_t  q_i,
   output logic                           valid_o
);
   if (SETTLE_CYC < 1) begin : g_bad_settle
      $error("SETTLE_CYC must be at least one");
   end

   logic [31:0] count_reg;
   logic [31:0] count_next;
   logic        valid_reg;
   logic        valid_next;

   always_comb begin
      count_next = count_reg;
      valid_next = 1'b0;
      if (!q_i.enable) begin
         count_next = 32'h0000_0000;
      end else if (!q_i.crystal) begin
         // RC and capacitor modes need no settle wait.
         valid_next = q_i.osc_good;
      end else if (count_reg < 32'(SETTLE_CYC)) begin
         // The amplitude detector reads falsely good during bias settle.
         count_next = count_reg + 32'h0000_0001;
      end else begin
         valid_next = q_i.osc_good;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         count_reg <= 32'h0000_0000;
         valid_reg <= 1'b0;
      end else begin
         count_reg <= count_next;
         valid_reg <= valid_next;
      end
   end

   assign valid_o = valid_reg;

   property p_no_early_valid;
      @(posedge clk_i) disable iff (rst_i)
         (q_i.enable && q_i.crystal && count_reg < 32'(SETTLE_CYC)) |=> !valid_reg;
   endproperty
   a_no_early_valid: assert property (p_no_early_valid) else $error("valid before settle");

   property p_rc_fast;
      @(posedge clk_i) disable iff (rst_i)
         (q_i.enable && !q_i.crystal && q_i.osc_good) |=> valid_reg;
   endproperty
   a_rc_fast: assert property (p_rc_fast) else $error("rc mode not valid at once");

   property p_off_invalid;
      @(posedge clk_i) disable iff (rst_i) !q_i.enable |=> !valid_reg;
   endproperty
   a_off_invalid: assert property (p_off_invalid) else $error("valid while disabled");
endmodule // osc_qualifier
`default_nettype wire

// >>> core/clk_select.sv
/*
 System clock source select with external oscillator qualification and a
 classic Wishbone register slave. Assumes a 100 MHz clock, synchronous
 inputs, and a glitch-free clock mux outside that follows sysclk_sel_o.
*/
// Decided for this implementation: the Wishbone register port.
// How it works
// - Hardware sets crystal valid when oscillator settles.
// - Internal oscillator usable immediately after enable.
// - External source only when low select bit set.
// - External clock stays available for peripherals.
// - RC and C modes need no wait.
`timescale 1ns/1ns
`default_nettype none
`include "clk_select_cfg.svh"
module clk_select #(
   parameter int SETTLE_CYC = `XTAL_SETTLE_CYC
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   input  wire logic        we_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   output logic             ack_o,
   input  wire logic        int_osc_en_i,
   input  wire logic        osc_good_i,
   output logic      [1:0]  sysclk_sel_o,
   output logic             ext_osc_en_o,
   output logic             periph_ext_clk_en_o,
   output logic      [2:0]  ext_osc_freq_range_o,
   output logic             irq_o
);
   if (SETTLE_CYC < 1) begin : g_bad_settle
      $error("SETTLE_CYC must be at least one");
   end

   logic [1:0]  sysclk_source_bits_reg;
   logic [1:0]  sysclk_source_bits_next;
   clk_select_pkg::ext_osc_cfg_t ext_cfg_reg;
   clk_select_pkg::ext_osc_cfg_t ext_cfg_next;
   logic [2:0]  stat_reg;
   logic [2:0]  stat_next;
   logic [2:0]  mask_reg;
   logic [2:0]  mask_next;
   logic [31:0] dat_reg;
   logic [31:0] dat_next;
   logic        ack_reg;
   logic        ack_next;
   logic        irq_reg;
   logic        irq_next;
   logic        valid_prev_reg;
   logic        ext_en_reg;
   logic        crystal_valid_flag;
   logic        req;
   logic        wr;
   logic        rd;
   logic [2:0]  events;
   clk_select_pkg::qual_in_t qual_in;

   assign req = cyc_i && stb_i && !ack_reg;
   assign wr  = req && we_i && sel_i[0];
   assign rd  = req && !we_i;

   // Modes 00x are off; any other mode powers the external circuit.
   assign qual_in = '{enable:   ext_cfg_reg.mode[2:1] != 2'b00,
                      crystal:  ext_cfg_reg.mode[2:1] == 2'b11,
                      osc_good: osc_good_i};

   osc_qualifier #(
      .SETTLE_CYC (SETTLE_CYC)
   ) u_qual (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .q_i     (qual_in),
      .valid_o (crystal_valid_flag)
   );

   assign events[`IRQ_VALID_RISE] = crystal_valid_flag && !valid_prev_reg;
   assign events[`IRQ_VALID_FALL] = !crystal_valid_flag && valid_prev_reg;
   assign events[`IRQ_BAD_SELECT] = wr && adr_i == `ADDR_CLKSRC && dat_i[1:0] == `SRC_RESERVED;

   always_comb begin
      sysclk_source_bits_next = sysclk_source_bits_reg;
      ext_cfg_next            = ext_cfg_reg;
      mask_next               = mask_reg;
      stat_next               = stat_reg;
      dat_next                = 32'h0000_0000;
      ack_next                = req;
      if (wr) begin
         unique case (adr_i)
            `ADDR_CLKSRC: begin
               // Code 11 is reserved, so such a write keeps the old source.
               if (dat_i[1:0] != `SRC_RESERVED) begin
                  sysclk_source_bits_next = dat_i[1:0];
               end
            end
            `ADDR_EXTOSC: begin
               ext_cfg_next.mode  = dat_i[`EXT_MODE_HI:`EXT_MODE_LO];
               ext_cfg_next.range = dat_i[`EXT_RANGE_HI:`EXT_RANGE_LO];
            end
            `ADDR_IRQ_MASK: mask_next = dat_i[2:0];
            default: ;
         endcase
      end
      if (rd) begin
         unique case (adr_i)
            `ADDR_CLKSRC: dat_next = {30'h0000_0000, sysclk_source_bits_reg};
            `ADDR_EXTOSC: dat_next = {24'h00_0000, crystal_valid_flag, ext_cfg_reg.mode,
                                      1'b0, ext_cfg_reg.range};
            `ADDR_IRQ_STATUS: begin
               dat_next  = {29'h0000_0000, stat_reg};
               stat_next = 3'h0;
            end
            `ADDR_IRQ_MASK: dat_next = {29'h0000_0000, mask_reg};
            `ADDR_STATUS: dat_next = {28'h000_0000, int_osc_en_i, ext_en_reg, sysclk_sel_o};
            default: dat_next = 32'h0000_0000;
         endcase
      end
      // A new event wins over the clearing read.
      stat_next = stat_next | events;
      irq_next  = |(stat_next & mask_next);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sysclk_source_bits_reg <= 2'h0;
         ext_cfg_reg            <= '0;
         stat_reg               <= 3'h0;
         mask_reg               <= 3'h0;
         dat_reg                <= 32'h0000_0000;
         ack_reg                <= 1'b0;
         irq_reg                <= 1'b0;
         valid_prev_reg         <= 1'b0;
         ext_en_reg             <= 1'b0;
      end else begin
         sysclk_source_bits_reg <= sysclk_source_bits_next;
         ext_cfg_reg            <= ext_cfg_next;
         stat_reg               <= stat_next;
         mask_reg               <= mask_next;
         dat_reg                <= dat_next;
         ack_reg                <= ack_next;
         irq_reg                <= irq_next;
         valid_prev_reg         <= crystal_valid_flag;
         ext_en_reg             <= qual_in.enable;
      end
   end

   // The block never gates the request: software owns the switch order.
   assign sysclk_sel_o         = sysclk_source_bits_reg;
   assign ext_osc_en_o         = ext_en_reg;
   assign periph_ext_clk_en_o  = ext_en_reg;
   assign ext_osc_freq_range_o = ext_cfg_reg.range;
   assign dat_o                = dat_reg;
   assign ack_o                = ack_reg;
   assign irq_o                = irq_reg;

   property p_ext_low_bit;
      @(posedge clk_i) disable iff (rst_i)
         $rose(sysclk_sel_o[0]) |-> $past(wr && adr_i == `ADDR_CLKSRC && dat_i[0]);
   endproperty
   a_ext_low_bit: assert property (p_ext_low_bit) else $error("external without low bit");

   property p_no_reserved;
      @(posedge clk_i) disable iff (rst_i) sysclk_sel_o != `SRC_RESERVED;
   endproperty
   a_no_reserved: assert property (p_no_reserved) else $error("reserved source selected");

   property p_sel_write;
      @(posedge clk_i) disable iff (rst_i)
         (wr && adr_i == `ADDR_CLKSRC && dat_i[1:0] != `SRC_RESERVED) |=> sysclk_sel_o == $past(dat_i[1:0]);
   endproperty
   a_sel_write: assert property (p_sel_write) else $error("source write not applied next cycle");

   property p_periph_clk;
      @(posedge clk_i) disable iff (rst_i)
         qual_in.enable |=> periph_ext_clk_en_o;
   endproperty
   a_periph_clk: assert property (p_periph_clk) else $error("peripheral clock lost");

   property p_ack_one;
      @(posedge clk_i) disable iff (rst_i) ack_o |=> !ack_o;
   endproperty
   a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");

   property p_irq;
      @(posedge clk_i) disable iff (rst_i)
         (events[`IRQ_VALID_RISE] && mask_reg[`IRQ_VALID_RISE]) |=> irq_o;
   endproperty
   a_irq: assert property (p_irq) else $error("valid rise did not interrupt");

   // The block never moves the system clock on its own; only software does.
   property p_src_hold;
      @(posedge clk_i) disable iff (rst_i)
         !(wr && adr_i == `ADDR_CLKSRC) |=> $stable(sysclk_sel_o);
   endproperty
   a_src_hold: assert property (p_src_hold) else $error("source changed without a write");

   property p_reserved_kept;
      @(posedge clk_i) disable iff (rst_i)
         (wr && adr_i == `ADDR_CLKSRC && dat_i[1:0] == `SRC_RESERVED)
            |=> $stable(sysclk_sel_o) && stat_reg[`IRQ_BAD_SELECT];
   endproperty
   a_reserved_kept: assert property (p_reserved_kept) else $error("reserved code not refused");

   property p_valid_read;
      @(posedge clk_i) disable iff (rst_i)
         (rd && adr_i == `ADDR_EXTOSC) |=> dat_o[`EXT_VALID_BIT] == $past(crystal_valid_flag);
   endproperty
   a_valid_read: assert property (p_valid_read) else $error("valid flag misread");

   property p_stat_clear;
      @(posedge clk_i) disable iff (rst_i)
         (rd && adr_i == `ADDR_IRQ_STATUS) |=> stat_reg == $past(events);
   endproperty
   a_stat_clear: assert property (p_stat_clear) else $error("status read did not clear");

   property p_ext_en_follow;
      @(posedge clk_i) disable iff (rst_i) ext_osc_en_o == $past(qual_in.enable);
   endproperty
   a_ext_en_follow: assert property (p_ext_en_follow) else $error("external enable out of step");
endmodule // clk_select
`default_nettype wire

// >>> test/osc_model.sv
/*
 Behavioural external oscillator: reports good amplitude a few cycles after
 its circuit is powered, and drops it at the next clock edge after power is removed.
 Assumes the power enable is synchronous to clk_i.
*/
`timescale 1ns/1ns
`default_nettype none
module osc_model #(
   parameter int START_CYC = 5
) (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic en_i,
   output logic      good_o
);
   int cnt;
   // Amplitude builds up only while powered, so a quick off and on restarts it.
   always_ff @(posedge clk_i) begin
      if (rst_i || !en_i) cnt <= 0;
      else if (cnt < START_CYC) cnt <= cnt + 1;
   end
   assign good_o = (cnt == START_CYC);
endmodule // osc_model
`default_nettype wire

// >>> test/system_clock_source_select_test.sv
/*
 Self-checking bench for the clock source select block over classic Wishbone.
 Assumes the design and the oscillator model are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module system_clock_source_select_test;
   typedef struct packed {
      logic [7:0] adr;
      logic [7:0] wdat;
      logic [7:0] rdat;
      logic [1:0] sel;
   } row_t;
   localparam row_t ROWS [4] = '{'{8'ha9, 8'h02, 8'h02, 2'h2}, '{8'ha9, 8'h03, 8'h02, 2'h2},
                                 '{8'h10, 8'hff, 8'h00, 2'h2}, '{8'ha9, 8'h00, 8'h00, 2'h0}};
   localparam int SETTLE = 20;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic [7:0]  adr_i = 8'h00;
   logic [31:0] dat_i = 32'h0;
   logic        we_i = 1'b0;
   logic [3:0]  sel_i = 4'h0;
   logic        cyc_i = 1'b0;
   logic        stb_i = 1'b0;
   logic        int_osc_en_i = 1'b1;
   logic        osc_good_i;
   logic [31:0] dat_o;
   logic [31:0] rd;
   logic        ack_o;
   logic [1:0]  sysclk_sel_o;
   logic        ext_osc_en_o;
   logic        periph_ext_clk_en_o;
   logic [2:0]  ext_osc_freq_range_o;
   logic        irq_o;
   int          miscompares = 0;
   int          num_checks = 0;
   int          cycles = 0;
   int          t;

   clk_select #(.SETTLE_CYC(SETTLE)) i_clk_select (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
      .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
      .int_osc_en_i(int_osc_en_i), .osc_good_i(osc_good_i), .sysclk_sel_o(sysclk_sel_o),
      .ext_osc_en_o(ext_osc_en_o), .periph_ext_clk_en_o(periph_ext_clk_en_o),
      .ext_osc_freq_range_o(ext_osc_freq_range_o), .irq_o(irq_o));
   osc_model i_osc_model (.clk_i(clk_i), .rst_i(rst_i), .en_i(ext_osc_en_o), .good_o(osc_good_i));

   always #5 clk_i = ~clk_i;

   task automatic results();
      $display("Checks %0d, mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         miscompares++;
         results();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One classic cycle; read data is taken at the edge where ack is seen high.
   task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d);
      adr_i <= a;
      we_i <= w;
      dat_i <= {24'h0, d};
      sel_i <= 4'h1;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      // Only ack or the bench timeout ends this wait.
      do begin
         @(posedge clk_i);
      end while (ack_o !== 1'b1);
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
      repeat (2) @(posedge clk_i);
   endtask

   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      check(32'({irq_o, ext_osc_en_o, periph_ext_clk_en_o, sysclk_sel_o}), 32'h0);
      wb(8'hc2, 1'b0, 8'h00);
      check(rd, 32'h8);
      foreach (ROWS[i]) begin
         wb(ROWS[i].adr, 1'b1, ROWS[i].wdat);
         wb(ROWS[i].adr, 1'b0, 8'h00);
         check(rd, 32'(ROWS[i].rdat));
         check(32'(sysclk_sel_o), 32'(ROWS[i].sel));
      end
      check(32'(irq_o), 32'h0);
      wb(8'hc1, 1'b1, 8'h07);
      check(32'(irq_o), 32'h1);
      wb(8'hc0, 1'b0, 8'h00);
      check(rd, 32'h4);
      check(32'(irq_o), 32'h0);
      wb(8'hc1, 1'b1, 8'h01);
      // Crystal start: software waits for the valid flag before switching.
      wb(8'hb1, 1'b1, 8'h77);
      t = cycles;
      check(32'({ext_osc_en_o, ext_osc_freq_range_o}), 32'hf);
      // A look inside the settle window must still find the flag low.
      wb(8'hb1, 1'b0, 8'h00);
      check(rd, 32'h77);
      repeat (SETTLE) @(posedge clk_i);
      do wb(8'hb1, 1'b0, 8'h00); while (rd[7] !== 1'b1 && cycles - t < 100);
      check(rd, 32'hf7);
      check(32'(cycles - t > 15), 32'h1);
      check(32'(irq_o), 32'h1);
      wb(8'ha9, 1'b1, 8'h01);
      check(32'(sysclk_sel_o), 32'h1);
      wb(8'hc2, 1'b0, 8'h00);
      check(rd, 32'hd);
      wb(8'ha9, 1'b1, 8'h00);
      check(32'({sysclk_sel_o, periph_ext_clk_en_o}), 32'h1);
      wb(8'hb1, 1'b1, 8'h43);
      wb(8'hb1, 1'b0, 8'h00);
      check(rd, 32'hc3);
      wb(8'hb1, 1'b1, 8'h00);
      check(32'({ext_osc_en_o, periph_ext_clk_en_o}), 32'h0);
      // The crystal rise and the fall at power-off both stay latched.
      wb(8'hc0, 1'b0, 8'h00);
      check(rd, 32'h3);
      // An RC start is valid long before a crystal window would end.
      wb(8'hb1, 1'b1, 8'h43);
      repeat (8) @(posedge clk_i);
      wb(8'hb1, 1'b0, 8'h00);
      check(rd, 32'hc3);
      rst_i <= 1'b1;
      int_osc_en_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      check(32'({irq_o, ext_osc_en_o, periph_ext_clk_en_o, sysclk_sel_o}), 32'h0);
      wb(8'hc2, 1'b0, 8'h00);
      check(rd, 32'h0);
      results();
   end
endmodule // system_clock_source_select_test
`default_nettype wire
